/* File: rtl/ars_pkg.sv */
// Constants and types shared by both ends of the converter sequencing link.
// Assumes one 100 MHz core clock; the sample clock is the core clock divided by two.
package ars_pkg;
  localparam int unsigned CORE_CLK_HZ = 100_000_000;
  localparam int unsigned CORE_PERIOD_NS = 10;
  localparam int unsigned SAMPLE_W = 14;
  localparam int unsigned CORE_PER_SAMPLE = 2;
  // Latency 17.5 sample periods, held as half periods
  localparam int unsigned LATENCY_HALF_SAMPLES = 35;
  localparam int unsigned LATENCY_CYC = LATENCY_HALF_SAMPLES * CORE_PER_SAMPLE / 2;
  localparam int unsigned POLARITY_EXTRA_CYC = CORE_PER_SAMPLE / 2;
  localparam int unsigned PIPE_DEPTH = LATENCY_CYC + POLARITY_EXTRA_CYC;
  localparam int unsigned SETTLE_SAMPLES = 1000;
  localparam int unsigned SETTLE_CYC = SETTLE_SAMPLES * CORE_PER_SAMPLE;
  localparam int unsigned POWER_ON_DELAY_MS = 10;
  localparam int unsigned POWER_ON_CYC = POWER_ON_DELAY_MS * (CORE_CLK_HZ / 1000);
  localparam int unsigned POWER_UP_MS = 40;
  localparam int unsigned POWER_UP_CYC = POWER_UP_MS * (CORE_CLK_HZ / 1000);
  localparam int unsigned RESET_WIDTH_US = 2;
  localparam int unsigned RESET_CYC = (RESET_WIDTH_US * 1000 + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;
  localparam int unsigned WRITE_DELAY_US = 2;
  localparam int unsigned WRITE_DELAY_CYC = (WRITE_DELAY_US * 1000 + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;
  localparam int unsigned SCLK_MIN_PERIOD_NS = 50;
  localparam int unsigned SCLK_HALF_CYC = (SCLK_MIN_PERIOD_NS / 2 + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;
  // Serial word: 4-bit address then 12-bit contents, first bit in is the top one
  localparam int unsigned WORD_W = 16;
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 12;
  localparam logic [3:0] LAST_BIT = 4'hf;
  localparam logic [ADDR_W-1:0] REG_DLL = 4'hd;
  localparam logic [ADDR_W-1:0] REG_TEST = 4'he;
  localparam logic [ADDR_W-1:0] REG_PDN = 4'hf;
  localparam int unsigned DLL_OFF_BIT = 1;
  localparam int unsigned TEST_LSB = 9;
  localparam int unsigned TEST_W = 2;
  localparam int unsigned PDN_BIT = 11;
  localparam logic DLL_OFF_RST = 1'h0;
  localparam logic [TEST_W-1:0] TEST_NORMAL = 2'h0;
  localparam logic [TEST_W-1:0] TEST_ZEROS = 2'h1;
  localparam logic [TEST_W-1:0] TEST_ONES = 2'h2;
  localparam logic [TEST_W-1:0] TEST_TOGGLE = 2'h3;
  localparam logic PDN_RST = 1'h0;

  typedef enum logic [4:0] {
    ST_PWR = 5'h01,
    ST_RST = 5'h02,
    ST_WAIT = 5'h04,
    ST_IDLE = 5'h08,
    ST_SHIFT = 5'h10
  } ars_ctrl_state_t;
endpackage

/* File: rtl/ars_link_if.sv */
// Pins between the converter end and the system controller end.
// Assumes both ends share core_clk; all signals are plain levels.
interface ars_link_if;
  logic adc_reset;
  logic serial_load_strobe_n;
  logic sclk;
  logic sdata;
  logic oe;
  logic clk_run;
  logic [ars_pkg::SAMPLE_W-1:0] sample_data;
  logic sample_strobe_out;

  modport adc (
    input adc_reset, serial_load_strobe_n, sclk, sdata, oe, clk_run,
    output sample_data, sample_strobe_out
  );
  modport ctrl (
    output adc_reset, serial_load_strobe_n, sclk, sdata, oe, clk_run,
    input sample_data, sample_strobe_out
  );
endinterface

/* File: rtl/ars_adc_end.sv */
// Converter end: serial configuration, power-up, settling and sample latency.
// Assumes the controller drives the link on core_clk; sample clock is core_clk / 2 gated by clk_run.
//
// Behaviour
// - Sample appears 17.5 sample clocks after capture.
// - Output timing settles within 1000 clocks after enable.
// - Valid data within 1000 clocks after power-down exit.
// - Valid data within 1000 clocks after clock restart.
// - Controller waits 10 ms before reset pulse.
// - Controller holds reset at least 2 us.
// - Controller waits 2 us before load strobe.
// - Output stable within 40 ms of power.
// - Falling polarity shifts output half a period.
// - Reset returns every register to normal setting.
// - Bits shift only while load strobe low.
module ars_adc_end #(
  parameter int unsigned POWER_UP_CYC = ars_pkg::POWER_UP_CYC,
  parameter int unsigned SETTLE_CYC = ars_pkg::SETTLE_CYC
) (
  input wire logic core_clk,
  input wire logic rst,
  ars_link_if.adc lnk,
  input wire logic [ars_pkg::SAMPLE_W-1:0] sample_in,
  input wire logic polarity_falling,
  output logic adc_stable,
  output logic dll_off
);

  // Serial configuration state
  logic sclk_prev_ff;
  logic nxt_sclk_prev;
  logic [3:0] bit_cnt_ff;
  logic [3:0] nxt_bit_cnt;
  logic [ars_pkg::WORD_W-1:0] shift_ff;
  logic [ars_pkg::WORD_W-1:0] nxt_shift;
  logic dll_off_ff;
  logic nxt_dll_off;
  logic [ars_pkg::TEST_W-1:0] test_ff;
  logic [ars_pkg::TEST_W-1:0] nxt_test;
  logic pdn_ff;
  logic nxt_pdn;
  logic [ars_pkg::WORD_W-1:0] word_in;

  always_comb begin
    nxt_sclk_prev = lnk.sclk;
    nxt_bit_cnt = bit_cnt_ff;
    nxt_shift = shift_ff;
    nxt_dll_off = dll_off_ff;
    nxt_test = test_ff;
    nxt_pdn = pdn_ff;
    word_in = {shift_ff[ars_pkg::WORD_W-2:0], lnk.sdata};
    if (lnk.adc_reset) begin
      nxt_bit_cnt = '0;
      nxt_dll_off = ars_pkg::DLL_OFF_RST;
      nxt_test = ars_pkg::TEST_NORMAL;
      nxt_pdn = ars_pkg::PDN_RST;
    end else if (lnk.serial_load_strobe_n) begin
      // Partial word dropped when strobe rises
      nxt_bit_cnt = '0;
    end else if (sclk_prev_ff && !lnk.sclk) begin
      nxt_shift = word_in;
      nxt_bit_cnt = bit_cnt_ff + 4'h1;
      if (bit_cnt_ff == ars_pkg::LAST_BIT) begin
        unique case (word_in[ars_pkg::WORD_W-1 -: ars_pkg::ADDR_W])
          ars_pkg::REG_DLL: nxt_dll_off = word_in[ars_pkg::DLL_OFF_BIT];
          ars_pkg::REG_TEST: nxt_test = word_in[ars_pkg::TEST_LSB +: ars_pkg::TEST_W];
          ars_pkg::REG_PDN: nxt_pdn = word_in[ars_pkg::PDN_BIT];
          default: nxt_pdn = pdn_ff;
        endcase
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sclk_prev_ff <= 1'b1;
      bit_cnt_ff <= '0;
      shift_ff <= '0;
      dll_off_ff <= ars_pkg::DLL_OFF_RST;
      test_ff <= ars_pkg::TEST_NORMAL;
      pdn_ff <= ars_pkg::PDN_RST;
    end else begin
      sclk_prev_ff <= nxt_sclk_prev;
      bit_cnt_ff <= nxt_bit_cnt;
      shift_ff <= nxt_shift;
      dll_off_ff <= nxt_dll_off;
      test_ff <= nxt_test;
      pdn_ff <= nxt_pdn;
    end
  end

  // Power-up, sample phase and settling state
  logic [31:0] pwr_cnt_ff;
  logic [31:0] nxt_pwr_cnt;
  logic pwr_done_ff;
  logic nxt_pwr_done;
  logic phase_ff;
  logic nxt_phase;
  logic oe_prev_ff;
  logic nxt_oe_prev;
  logic run_prev_ff;
  logic nxt_run_prev;
  logic [31:0] settle_cnt_ff;
  logic [31:0] nxt_settle_cnt;
  logic stable_ff;
  logic nxt_stable;
  logic run;
  logic sample_now;
  logic restart;
  logic active;

  always_comb begin
    run = lnk.clk_run && pwr_done_ff;
    sample_now = run && !phase_ff;
    active = pwr_done_ff && lnk.oe && lnk.clk_run && !pdn_ff;
    restart = (lnk.oe && !oe_prev_ff)
      || (pdn_ff && !nxt_pdn)
      || (lnk.clk_run && !run_prev_ff)
      || lnk.adc_reset;
    nxt_pwr_cnt = pwr_cnt_ff;
    nxt_pwr_done = pwr_done_ff;
    if (!pwr_done_ff) begin
      nxt_pwr_cnt = pwr_cnt_ff + 32'h1;
      if (pwr_cnt_ff == 32'(POWER_UP_CYC - 1)) begin
        nxt_pwr_done = 1'b1;
      end
    end
    nxt_phase = run ? !phase_ff : phase_ff;
    nxt_oe_prev = lnk.oe;
    nxt_run_prev = lnk.clk_run;
    nxt_settle_cnt = settle_cnt_ff;
    if (restart) begin
      nxt_settle_cnt = 32'(SETTLE_CYC);
    end else if (active && settle_cnt_ff != 32'h0) begin
      nxt_settle_cnt = settle_cnt_ff - 32'h1;
    end
    nxt_stable = active && !restart && settle_cnt_ff == 32'h0;
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pwr_cnt_ff <= '0;
      pwr_done_ff <= 1'b0;
      phase_ff <= 1'b0;
      oe_prev_ff <= 1'b0;
      run_prev_ff <= 1'b0;
      settle_cnt_ff <= 32'(SETTLE_CYC);
      stable_ff <= 1'b0;
    end else begin
      pwr_cnt_ff <= nxt_pwr_cnt;
      pwr_done_ff <= nxt_pwr_done;
      phase_ff <= nxt_phase;
      oe_prev_ff <= nxt_oe_prev;
      run_prev_ff <= nxt_run_prev;
      settle_cnt_ff <= nxt_settle_cnt;
      stable_ff <= nxt_stable;
    end
  end

  // Sample pipeline and output stage
  logic [ars_pkg::SAMPLE_W-1:0] pipe_ff [0:ars_pkg::PIPE_DEPTH-1];
  logic [ars_pkg::SAMPLE_W-1:0] nxt_pipe [0:ars_pkg::PIPE_DEPTH-1];
  logic [ars_pkg::PIPE_DEPTH-1:0] mark_ff;
  logic [ars_pkg::PIPE_DEPTH-1:0] nxt_mark;
  logic pol_ff;
  logic nxt_pol;
  logic [ars_pkg::SAMPLE_W-1:0] data_ff;
  logic [ars_pkg::SAMPLE_W-1:0] nxt_data;
  logic strobe_ff;
  logic nxt_strobe;
  logic [ars_pkg::SAMPLE_W-1:0] tap_data;
  logic tap_mark;

  assign nxt_pipe[0] = sample_now ? sample_in : pipe_ff[0];
  assign nxt_mark[0] = run ? sample_now : mark_ff[0];

  genvar gi;
  generate
    for (gi = 1; gi < ars_pkg::PIPE_DEPTH; gi++) begin : g_pipe
      assign nxt_pipe[gi] = run ? pipe_ff[gi-1] : pipe_ff[gi];
      assign nxt_mark[gi] = run ? mark_ff[gi-1] : mark_ff[gi];
    end
  endgenerate

  always_comb begin
    nxt_pol = polarity_falling;
    if (pol_ff) begin
      tap_data = pipe_ff[ars_pkg::PIPE_DEPTH-1];
      tap_mark = mark_ff[ars_pkg::PIPE_DEPTH-1];
    end else begin
      tap_data = pipe_ff[ars_pkg::LATENCY_CYC-1];
      tap_mark = mark_ff[ars_pkg::LATENCY_CYC-1];
    end
    nxt_data = data_ff;
    nxt_strobe = 1'b0;
    if (!lnk.oe || pdn_ff || !pwr_done_ff) begin
      nxt_data = '0;
    end else if (run) begin
      // Far tap mark gives the edge mid-word for either tap; quiet while the pipeline fills
      nxt_strobe = mark_ff[ars_pkg::PIPE_DEPTH-1];
      if (tap_mark) begin
        unique case (test_ff)
          ars_pkg::TEST_NORMAL: nxt_data = tap_data;
          ars_pkg::TEST_ZEROS: nxt_data = '0;
          ars_pkg::TEST_ONES: nxt_data = '1;
          ars_pkg::TEST_TOGGLE: nxt_data = ~data_ff;
        endcase
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < ars_pkg::PIPE_DEPTH; i++) begin
        pipe_ff[i] <= '0;
      end
      mark_ff <= '0;
      pol_ff <= 1'b0;
      data_ff <= '0;
      strobe_ff <= 1'b0;
    end else begin
      for (int i = 0; i < ars_pkg::PIPE_DEPTH; i++) begin
        pipe_ff[i] <= nxt_pipe[i];
      end
      mark_ff <= nxt_mark;
      pol_ff <= nxt_pol;
      data_ff <= nxt_data;
      strobe_ff <= nxt_strobe;
    end
  end

  assign lnk.sample_data = data_ff;
  assign lnk.sample_strobe_out = strobe_ff;
  assign adc_stable = stable_ff;
  assign dll_off = dll_off_ff;

endmodule // ars_adc_end

/* File: rtl/ars_ctrl_end.sv */
// Controller end: power-on and reset sequencing, serial writes, discard of unsettled data.
// Assumes the converter end shares core_clk and reads the link pins directly.
module ars_ctrl_end #(
  parameter int unsigned POWER_ON_CYC = ars_pkg::POWER_ON_CYC,
  parameter int unsigned SETTLE_CYC = ars_pkg::SETTLE_CYC
) (
  input wire logic core_clk,
  input wire logic rst,
  ars_link_if.ctrl lnk,
  input wire logic wr_req,
  input wire logic [ars_pkg::ADDR_W-1:0] wr_addr,
  input wire logic [ars_pkg::DATA_W-1:0] wr_data,
  input wire logic oe_req,
  input wire logic clk_run_req,
  input wire logic pol_falling,
  output logic wr_ready,
  output logic data_ok,
  output logic rx_valid,
  output logic [ars_pkg::SAMPLE_W-1:0] rx_data
);

  ars_pkg::ars_ctrl_state_t state_ff;
  ars_pkg::ars_ctrl_state_t nxt_state;
  logic [31:0] cnt_ff;
  logic [31:0] nxt_cnt;
  logic adc_rst_ff;
  logic nxt_adc_rst;
  logic sen_n_ff;
  logic nxt_sen_n;
  logic sclk_ff;
  logic nxt_sclk;
  logic sdata_ff;
  logic nxt_sdata;
  logic [ars_pkg::WORD_W-1:0] word_ff;
  logic [ars_pkg::WORD_W-1:0] nxt_word;
  logic [ars_pkg::WORD_W-1:0] cmd_ff;
  logic [ars_pkg::WORD_W-1:0] nxt_cmd;
  logic [3:0] bits_ff;
  logic [3:0] nxt_bits;
  logic ready_ff;
  logic nxt_ready;
  logic pdn_ff;
  logic nxt_pdn;

  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff + 32'h1;
    nxt_adc_rst = adc_rst_ff;
    nxt_sen_n = sen_n_ff;
    nxt_sclk = sclk_ff;
    nxt_sdata = sdata_ff;
    nxt_word = word_ff;
    nxt_cmd = cmd_ff;
    nxt_bits = bits_ff;
    nxt_ready = ready_ff;
    nxt_pdn = pdn_ff;
    unique case (state_ff)
      ars_pkg::ST_PWR: begin
        if (cnt_ff == 32'(POWER_ON_CYC - 1)) begin
          nxt_state = ars_pkg::ST_RST;
          nxt_adc_rst = 1'b1;
          nxt_cnt = '0;
        end
      end
      ars_pkg::ST_RST: begin
        nxt_pdn = ars_pkg::PDN_RST;
        if (cnt_ff == 32'(ars_pkg::RESET_CYC - 1)) begin
          nxt_state = ars_pkg::ST_WAIT;
          nxt_adc_rst = 1'b0;
          nxt_cnt = '0;
        end
      end
      ars_pkg::ST_WAIT: begin
        if (cnt_ff == 32'(ars_pkg::WRITE_DELAY_CYC - 1)) begin
          nxt_state = ars_pkg::ST_IDLE;
          nxt_ready = 1'b1;
        end
      end
      ars_pkg::ST_IDLE: begin
        nxt_cnt = '0;
        if (wr_req) begin
          nxt_state = ars_pkg::ST_SHIFT;
          nxt_cmd = {wr_addr, wr_data};
          nxt_word = {wr_addr, wr_data};
          nxt_sdata = wr_addr[ars_pkg::ADDR_W-1];
          nxt_sen_n = 1'b0;
          nxt_bits = '0;
          nxt_ready = 1'b0;
        end
      end
      ars_pkg::ST_SHIFT: begin
        if (cnt_ff == 32'(ars_pkg::SCLK_HALF_CYC - 1)) begin
          nxt_cnt = '0;
          if (sclk_ff) begin
            nxt_sclk = 1'b0;
          end else if (bits_ff == ars_pkg::LAST_BIT) begin
            nxt_sclk = 1'b1;
            nxt_sen_n = 1'b1;
            nxt_state = ars_pkg::ST_IDLE;
            nxt_ready = 1'b1;
            if (cmd_ff[ars_pkg::WORD_W-1 -: ars_pkg::ADDR_W] == ars_pkg::REG_PDN) begin
              nxt_pdn = cmd_ff[ars_pkg::PDN_BIT];
            end
          end else begin
            nxt_sclk = 1'b1;
            nxt_bits = bits_ff + 4'h1;
            nxt_word = {word_ff[ars_pkg::WORD_W-2:0], 1'b0};
            nxt_sdata = word_ff[ars_pkg::WORD_W-2];
          end
        end
      end
    endcase
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_ff <= ars_pkg::ST_PWR;
      cnt_ff <= '0;
      adc_rst_ff <= 1'b0;
      sen_n_ff <= 1'b1;
      sclk_ff <= 1'b1;
      sdata_ff <= 1'b0;
      word_ff <= '0;
      cmd_ff <= '0;
      bits_ff <= '0;
      ready_ff <= 1'b0;
      pdn_ff <= ars_pkg::PDN_RST;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      adc_rst_ff <= nxt_adc_rst;
      sen_n_ff <= nxt_sen_n;
      sclk_ff <= nxt_sclk;
      sdata_ff <= nxt_sdata;
      word_ff <= nxt_word;
      cmd_ff <= nxt_cmd;
      bits_ff <= nxt_bits;
      ready_ff <= nxt_ready;
      pdn_ff <= nxt_pdn;
    end
  end

  // Discard window and sample capture
  logic oe_ff;
  logic run_ff;
  logic [31:0] settle_ff;
  logic [31:0] nxt_settle;
  logic ok_ff;
  logic nxt_ok;
  logic strobe_prev_ff;
  logic rx_valid_ff;
  logic nxt_rx_valid;
  logic [ars_pkg::SAMPLE_W-1:0] rx_data_ff;
  logic [ars_pkg::SAMPLE_W-1:0] nxt_rx_data;
  logic restart;
  logic live;
  logic strobe_edge;

  always_comb begin
    live = oe_ff && run_ff && !pdn_ff && !adc_rst_ff && state_ff != ars_pkg::ST_PWR;
    restart = (oe_req && !oe_ff)
      || (pdn_ff && !nxt_pdn)
      || (clk_run_req && !run_ff)
      || adc_rst_ff;
    nxt_settle = settle_ff;
    if (restart) begin
      nxt_settle = 32'(SETTLE_CYC);
    end else if (live && settle_ff != 32'h0) begin
      nxt_settle = settle_ff - 32'h1;
    end
    nxt_ok = live && !restart && settle_ff == 32'h0;
    strobe_edge = pol_falling ? (strobe_prev_ff && !lnk.sample_strobe_out)
      : (!strobe_prev_ff && lnk.sample_strobe_out);
    nxt_rx_valid = ok_ff && strobe_edge;
    nxt_rx_data = nxt_rx_valid ? lnk.sample_data : rx_data_ff;
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      oe_ff <= 1'b0;
      run_ff <= 1'b0;
      settle_ff <= 32'(SETTLE_CYC);
      ok_ff <= 1'b0;
      strobe_prev_ff <= 1'b0;
      rx_valid_ff <= 1'b0;
      rx_data_ff <= '0;
    end else begin
      oe_ff <= oe_req;
      run_ff <= clk_run_req;
      settle_ff <= nxt_settle;
      ok_ff <= nxt_ok;
      strobe_prev_ff <= lnk.sample_strobe_out;
      rx_valid_ff <= nxt_rx_valid;
      rx_data_ff <= nxt_rx_data;
    end
  end

  assign lnk.adc_reset = adc_rst_ff;
  assign lnk.serial_load_strobe_n = sen_n_ff;
  assign lnk.sclk = sclk_ff;
  assign lnk.sdata = sdata_ff;
  assign lnk.oe = oe_ff;
  assign lnk.clk_run = run_ff;
  assign wr_ready = ready_ff;
  assign data_ok = ok_ff;
  assign rx_valid = rx_valid_ff;
  assign rx_data = rx_data_ff;

endmodule // ars_ctrl_end

/* File: testbench/ars_link_sva.sv */
// Checker for the converter sequencing link and the user-side flags beside it.
// Assumes one core_clk domain and an active-high asynchronous rst.
module ars_link_sva #(
  parameter int unsigned POWER_ON_CYC = 50,
  parameter int unsigned SETTLE_CYC = 40
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic adc_reset,
  input wire logic serial_load_strobe_n,
  input wire logic sclk,
  input wire logic oe,
  input wire logic clk_run,
  input wire logic [ars_pkg::SAMPLE_W-1:0] sample_data,
  input wire logic sample_strobe_out,
  input wire logic adc_stable,
  input wire logic data_ok,
  input wire logic rx_valid
);
  localparam int SETTLE_LIM = SETTLE_CYC + 8;
  logic [15:0] up_ff, nxt_up, hi_ff, nxt_hi, lo_ff, nxt_lo, run_ff, nxt_run;

  // Cycles since reset, within the reset pulse, after it, and of running output
  always_comb begin
    nxt_up = (&up_ff) ? up_ff : up_ff + 16'h1;
    nxt_hi = adc_reset ? hi_ff + 16'h1 : 16'h0;
    nxt_lo = adc_reset ? 16'h0 : ((&lo_ff) ? lo_ff : lo_ff + 16'h1);
    nxt_run = (!oe || !clk_run || adc_reset) ? 16'h0 : ((&run_ff) ? run_ff : run_ff + 16'h1);
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      up_ff <= 16'h0;
      hi_ff <= 16'h0;
      lo_ff <= 16'h0;
      run_ff <= 16'h0;
    end else begin
      up_ff <= nxt_up;
      hi_ff <= nxt_hi;
      lo_ff <= nxt_lo;
      run_ff <= nxt_run;
    end
  end

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  chk_power_on_wait: assert property ($rose(adc_reset) |-> up_ff >= POWER_ON_CYC)
    else $error("reset pulse before power-on wait");
  chk_reset_width: assert property ($fell(adc_reset) |-> hi_ff >= ars_pkg::RESET_CYC)
    else $error("reset pulse too short");
  chk_write_delay: assert property ($fell(serial_load_strobe_n) |-> !adc_reset && lo_ff >= ars_pkg::WRITE_DELAY_CYC)
    else $error("load strobe too soon after reset");
  chk_shift_gate: assert property ($fell(sclk) |-> !serial_load_strobe_n)
    else $error("serial clock falls outside load window");
  chk_strobe_pulse: assert property (sample_strobe_out |=> !sample_strobe_out)
    else $error("sample strobe longer than one cycle");
  chk_oe_quiet: assert property (!oe [*2] |-> sample_data == '0 && !sample_strobe_out)
    else $error("output active while disabled");
  chk_clk_stop: assert property (!clk_run [*2] |-> !sample_strobe_out)
    else $error("strobe while sample clock stopped");
  chk_settle_min: assert property ($rose(adc_stable) |-> run_ff >= SETTLE_CYC)
    else $error("stable before settle count");
  chk_oe_bound: assert property ($rose(oe) && clk_run |-> ##[1:SETTLE_LIM] adc_stable)
    else $error("no stable output after enable");
  chk_wake_bound: assert property ($rose(clk_run) && oe |-> ##[1:SETTLE_LIM] adc_stable)
    else $error("no stable output after clock restart");
  chk_ok_gate: assert property (rx_valid |-> $past(data_ok))
    else $error("sample passed during discard window");
endmodule // ars_link_sva

/* File: testbench/adc_reset_wakeup_sequencing_tb.sv */
// Testbench: both ends joined, plus a converter end driven directly by the bench.
// Assumes one 100 MHz clock and shortened power and settle counts.
module adc_reset_wakeup_sequencing_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned PON = 50;
  localparam int unsigned PUP = 100;
  localparam int unsigned SET = 40;
  localparam logic [15:0] DLL_W = {ars_pkg::REG_DLL, 12'h001 << ars_pkg::DLL_OFF_BIT};
  localparam logic [15:0] PDN_W = {ars_pkg::REG_PDN, 12'h001 << ars_pkg::PDN_BIT};
  logic core_clk, rst, wr_req, oe_req, run_req, pol, wr_ready, data_ok, rx_valid, stable, dll_off, dll_off_b;
  logic [3:0] wr_addr;
  logic [11:0] wr_data;
  logic [13:0] sin, rx_data;
  logic [15:0] cap;
  int err_total, n_compared, cyc, n, n_bits;
  ars_link_if lnk ();
  ars_link_if lnk_b ();

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  ars_adc_end #(.POWER_UP_CYC(PUP), .SETTLE_CYC(SET)) i_ars_adc_end (.core_clk(core_clk), .rst(rst), .lnk(lnk.adc),
    .sample_in(sin), .polarity_falling(pol), .adc_stable(stable), .dll_off(dll_off));
  ars_ctrl_end #(.POWER_ON_CYC(PON), .SETTLE_CYC(SET)) i_ars_ctrl_end (.core_clk(core_clk), .rst(rst),
    .lnk(lnk.ctrl), .wr_req(wr_req), .wr_addr(wr_addr), .wr_data(wr_data), .oe_req(oe_req),
    .clk_run_req(run_req), .pol_falling(pol), .wr_ready(wr_ready), .data_ok(data_ok), .rx_valid(rx_valid),
    .rx_data(rx_data));
  ars_adc_end #(.POWER_UP_CYC(PUP), .SETTLE_CYC(SET)) i_ars_adc_end_b (.core_clk(core_clk), .rst(rst),
    .lnk(lnk_b.adc), .sample_in(sin), .polarity_falling(1'b0), .adc_stable(), .dll_off(dll_off_b));
  ars_link_sva #(.POWER_ON_CYC(PON), .SETTLE_CYC(SET)) i_ars_link_sva (.core_clk(core_clk), .rst(rst),
    .adc_reset(lnk.adc_reset), .serial_load_strobe_n(lnk.serial_load_strobe_n), .sclk(lnk.sclk), .oe(lnk.oe),
    .clk_run(lnk.clk_run), .sample_data(lnk.sample_data), .sample_strobe_out(lnk.sample_strobe_out),
    .adc_stable(stable), .data_ok(data_ok), .rx_valid(rx_valid));

  // Wire monitor: bits taken on serial clock falls inside the load window
  always @(negedge lnk.sclk) begin
    if (!lnk.serial_load_strobe_n) begin
      cap = {cap[14:0], lnk.sdata};
      n_bits++;
    end
  end

  task automatic chk_bit(input logic got, input logic exp, input string what);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %0t %s got %b exp %b", $time, what, got, exp);
    end
  endtask

  task automatic chk_word(input logic [15:0] got, input logic [15:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic tick;
    @(negedge core_clk);
    n++;
  endtask

  task automatic wr(input logic [15:0] w);
    n = 0;
    while (wr_ready !== 1'b1 && n < 300) tick;
    n_bits = 0;
    wr_req = 1'b1;
    {wr_addr, wr_data} = w;
    tick;
    wr_req = 1'b0;
    tick;
    n = 0;
    while (wr_ready !== 1'b1 && n < 300) tick;
    chk_word(cap, w, "serial word");
    chk_word(16'(n_bits), 16'h0010, "serial bit count");
    chk_bit(lnk.sclk & lnk.serial_load_strobe_n, 1'b1, "serial idle");
  endtask

  // Output held back first, then stable within the settle bound, then accepted
  task automatic settle;
    n = 0;
    repeat (2) tick;
    chk_bit(stable | data_ok, 1'b0, "early stable");
    while (stable !== 1'b1 && n < 300) tick;
    chk_bit(n <= SET + 8, 1'b1, "settle bound");
    while (data_ok !== 1'b1 && n < 300) tick;
    chk_bit(data_ok, 1'b1, "data accepted");
  endtask

  task automatic lat(input logic p);
    int exp_n;
    exp_n = ars_pkg::LATENCY_CYC + (p ? ars_pkg::POLARITY_EXTRA_CYC : 0);
    exp_n = exp_n + 2 - exp_n % 2;
    run_req = 1'b0;
    pol = p;
    repeat (4) tick;
    run_req = 1'b1;
    sin = 14'h0a5a;
    repeat (60) tick;
    sin = 14'h15a5;
    n = 0;
    while (lnk.sample_data !== 14'h15a5 && n < 100) tick;
    sin = 14'h2c3c;
    n = 0;
    while (lnk.sample_data !== 14'h2c3c && n < 100) tick;
    chk_word(16'(n), 16'(exp_n), "latency");
    repeat (4) tick;
    chk_word(16'(rx_data), 16'h2c3c, "captured sample");
  endtask

  task automatic send_b(input logic [15:0] w, input logic sel_n);
    lnk_b.serial_load_strobe_n = sel_n;
    for (int i = 15; i >= 0; i--) begin
      lnk_b.sdata = w[i];
      repeat (3) tick;
      lnk_b.sclk = 1'b0;
      repeat (3) tick;
      lnk_b.sclk = 1'b1;
    end
    lnk_b.serial_load_strobe_n = 1'b1;
    lnk_b.sdata = ~lnk_b.sdata;
    tick;
  endtask

  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 12000) begin
      err_total++;
      $display("ERROR %0t run too long", $time);
      tally_and_finish;
    end
  end

  initial begin
    rst = 1'b1;
    {wr_req, wr_addr, wr_data, oe_req, run_req, pol, sin, cap} = '0;
    {err_total, n_compared, cyc, n, n_bits} = '0;
    {lnk_b.adc_reset, lnk_b.sdata, lnk_b.oe, lnk_b.clk_run} = '0;
    {lnk_b.serial_load_strobe_n, lnk_b.sclk} = 2'h3;
    repeat (4) @(negedge core_clk);
    rst = 1'b0;
    while (lnk.adc_reset !== 1'b1 && n < 500) tick;
    chk_bit(n >= PON, 1'b1, "power-on wait");
    n = 0;
    while (lnk.adc_reset === 1'b1 && n < 500) tick;
    chk_word(16'(n), 16'(ars_pkg::RESET_CYC), "reset width");
    n = 0;
    while (wr_ready !== 1'b1 && n < 500) tick;
    chk_bit(n >= ars_pkg::WRITE_DELAY_CYC, 1'b1, "write delay");
    $display("test startup done");
    oe_req = 1'b1;
    run_req = 1'b1;
    settle;
    $display("test enable done");
    lat(1'b0);
    lat(1'b1);
    $display("test latency done");
    wr(DLL_W);
    chk_bit(dll_off, 1'b1, "dll off");
    wr({ars_pkg::REG_TEST, 12'h400});
    repeat (2) tick;
    chk_word(16'(lnk.sample_data), 16'h3fff, "test ones");
    wr({ars_pkg::REG_TEST, 12'h000});
    repeat (2) tick;
    chk_word(16'(lnk.sample_data), 16'h2c3c, "test normal");
    wr(PDN_W);
    repeat (4) tick;
    chk_bit(stable, 1'b0, "power down");
    chk_word(16'(lnk.sample_data), 16'h0000, "power down data");
    wr({ars_pkg::REG_PDN, 12'h000});
    settle;
    $display("test wake done");
    run_req = 1'b0;
    repeat (20) tick;
    chk_bit(lnk.sample_strobe_out | stable, 1'b0, "clock stopped");
    run_req = 1'b1;
    settle;
    oe_req = 1'b0;
    repeat (4) tick;
    chk_word(16'(lnk.sample_data), 16'h0000, "disabled data");
    oe_req = 1'b1;
    settle;
    $display("test restart done");
    send_b(DLL_W, 1'b1);
    chk_bit(dll_off_b, 1'b0, "shift without window");
    send_b(DLL_W, 1'b0);
    chk_bit(dll_off_b, 1'b1, "shift in window");
    lnk_b.adc_reset = 1'b1;
    repeat (ars_pkg::RESET_CYC) tick;
    lnk_b.adc_reset = 1'b0;
    repeat (2) tick;
    chk_bit(dll_off_b, 1'b0, "reset restores config");
    $display("test direct link done");
    tally_and_finish;
  end
endmodule // adc_reset_wakeup_sequencing_tb
